// [hdl/bridge_transfer_policy_ctrl_map.svh]
// constants of the bridge transfer policy controls
// assumes byte-wide configuration access at printed offsets
//
// Contract
// - processor_write_control bit 1 enables posting of processor writes to PCI.
// - pci_read_write_control bit 0 enables posting of PCI writes toward the host.
// - pci_read_write_control bit 1 merges back-to-back sequential write-combining lines into one burst.
// - bit 8 makes Memory Read fetch full host lines, otherwise partial reads.
// - bits 9 and 8 make Memory Read fetch a line plus three prefetched; bit 9 alone does nothing.
// - bit 5 makes Memory Read Multiple fetch full host lines, otherwise partial reads.
// - bits 6 and 5 make Memory Read Multiple prefetch three more lines; bit 6 alone does nothing.
// - bit 3 makes Memory Read Line fetch full host lines, otherwise partial reads.
// - bits 4 and 3 make Memory Read Line prefetch three more lines; bit 4 alone does nothing.
// - prefetching never crosses a 4 Kbyte aligned boundary.
// - the system-management window is the range on smm_base_in and smm_limit_in, applied unless the enable register's override bit is set.
// - sysmgmt_ram_enable bit 3 makes the bridge disregard the system-management gap.
// - with override clear, accesses in range while the select is asserted are ignored.
// - accesses outside the range decode the same whatever the select does.
`ifndef BRIDGE_TRANSFER_POLICY_CTRL_MAP_SVH
`define BRIDGE_TRANSFER_POLICY_CTRL_MAP_SVH
`define OFS_PROC_WR_CTRL     8'h53
`define OFS_PCI_RW_CTRL_LO   8'h54
`define OFS_PCI_RW_CTRL_HI   8'h55
`define OFS_SMM_ENABLE       8'h57
`define RST_PROC_WR_CTRL     8'h00
`define RST_PCI_RW_CTRL      16'h0000
`define RST_SMM_ENABLE       8'h00
`define MASK_PROC_WR_CTRL    8'h02
`define MASK_PCI_RW_CTRL     16'h037B
`define MASK_SMM_ENABLE      8'h08
`define BIT_OUT_POST         1
`define BIT_IN_POST          0
`define BIT_BURST_ASM        1
`define BIT_MR_LINE          8
`define BIT_MR_PREF          9
`define BIT_MRM_LINE         5
`define BIT_MRM_PREF         6
`define BIT_MRL_LINE         3
`define BIT_MRL_PREF         4
`define BIT_SMM_OVERRIDE     3
`define PAGE_BYTES           4096
`define PREFETCH_LINES       4
`endif

// [hdl/bridge_transfer_policy_ctrl_pkg.sv]
// types of the bridge transfer policy controls
// assumes the map header is included by the design file
package bridge_transfer_policy_ctrl_pkg;
    typedef enum logic [1:0] {
        CMD_MEM_READ      = 2'h0,
        CMD_MEM_READ_LINE = 2'h1,
        CMD_MEM_READ_MULT = 2'h2,
        CMD_NONE          = 2'h3
    } pci_read_cmd_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } issue_state_t;
endpackage

// [hdl/bridge_transfer_policy_ctrl.sv]
// transfer policy registers and host-side read planning of the bridge
// assumes one clock, synchronous inputs, byte configuration cycles
`timescale 1ns/1ps
`default_nettype none
`include "bridge_transfer_policy_ctrl_map.svh"

module xfer_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign push = wr_valid_in & wr_ready_out;
    assign pop  = rd_valid_out & rd_ready_in;
    assign rd_data_out = mem_reg[rptr_reg];

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_reg[wptr_reg] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wptr_reg     <= '0;
            rptr_reg     <= '0;
            count_reg    <= '0;
            wr_ready_out <= 1'b0;
            rd_valid_out <= 1'b0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            count_reg    <= count_next;
            wr_ready_out <= (count_next != DEPTH[AW:0]);
            rd_valid_out <= (count_next != '0);
        end
    end
endmodule

module bridge_transfer_policy_ctrl
    import bridge_transfer_policy_ctrl_pkg::*;
#(
    parameter int ADDR_W     = 32,
    parameter int LINE_BYTES = 32,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    // configuration space byte access
    input  wire logic              cfg_wr_in,
    input  wire logic              cfg_rd_in,
    input  wire logic [7:0]        cfg_addr_in,
    input  wire logic [7:0]        cfg_wdata_in,
    output logic      [7:0]        cfg_rdata_out,
    // posting enables
    output logic                   out_post_en_out,
    output logic                   in_post_en_out,
    // processor writes to PCI
    input  wire logic              host_wr_valid_in,
    input  wire logic [ADDR_W-1:0] host_wr_addr_in,
    input  wire logic              host_wr_combining_in,
    input  wire logic              host_wr_full_line_in,
    output logic                   host_wr_post_out,
    output logic                   pci_burst_continue_out,
    // PCI read requests
    input  wire logic              pci_rd_valid_in,
    output logic                   pci_rd_ready_out,
    input  wire logic [1:0]        pci_rd_cmd_in,
    input  wire logic [ADDR_W-1:0] pci_rd_addr_in,
    // host read plan
    output logic                   host_rd_valid_out,
    input  wire logic              host_rd_ready_in,
    output logic      [ADDR_W-1:0] host_rd_addr_out,
    output logic                   host_rd_full_line_out,
    output logic      [2:0]        host_rd_lines_out,
    // system-management decode
    input  wire logic              dec_valid_in,
    input  wire logic [ADDR_W-1:0] dec_addr_in,
    input  wire logic              normal_hit_in,
    input  wire logic              sysmgmt_memory_select_n_in,
    input  wire logic [ADDR_W-1:0] smm_base_in,
    input  wire logic [ADDR_W-1:0] smm_limit_in,
    output logic                   dec_claim_out
);
    localparam int OFF_W = $clog2(LINE_BYTES);
    localparam int FW    = 2 + ADDR_W;
    localparam logic [15:0] PCI_READ_WRITE_CONTROL_MASK = `MASK_PCI_RW_CTRL;

    logic [7:0]        processor_write_control_reg;
    logic [15:0]       pci_read_write_control_reg;
    logic [7:0]        sysmgmt_ram_enable_reg;
    logic [ADDR_W-1:0] wr_next_addr_reg;
    logic              wr_chain_reg;
    logic              fifo_valid;
    logic              fifo_ready;
    logic [FW-1:0]     fifo_data;
    issue_state_t      state_reg;
    pci_read_cmd_t     fifo_cmd;
    logic [ADDR_W-1:0] fifo_addr;
    logic              plan_line;
    logic              plan_pref;
    logic              in_smm_range;

    // lines until the next 4 Kbyte boundary, capped at the prefetch depth
    function automatic logic [2:0] lines_to_page(input logic [ADDR_W-1:0] addr);
        logic [12:0] left;
        left = 13'(`PAGE_BYTES) - {1'b0, addr[11:0]};
        left = left + 13'(LINE_BYTES - 1);
        left = left >> OFF_W;
        if (left >= 13'(`PREFETCH_LINES)) begin
            lines_to_page = 3'(`PREFETCH_LINES);
        end else begin
            lines_to_page = left[2:0];
        end
    endfunction

    // configuration writes
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            processor_write_control_reg <= `RST_PROC_WR_CTRL;
            pci_read_write_control_reg  <= `RST_PCI_RW_CTRL;
            sysmgmt_ram_enable_reg      <= `RST_SMM_ENABLE;
        end else if (cfg_wr_in) begin
            if (cfg_addr_in == `OFS_PROC_WR_CTRL) begin
                processor_write_control_reg <= cfg_wdata_in & `MASK_PROC_WR_CTRL;
            end else if (cfg_addr_in == `OFS_PCI_RW_CTRL_LO) begin
                pci_read_write_control_reg[7:0] <= cfg_wdata_in & PCI_READ_WRITE_CONTROL_MASK[7:0];
            end else if (cfg_addr_in == `OFS_PCI_RW_CTRL_HI) begin
                pci_read_write_control_reg[15:8] <= cfg_wdata_in & PCI_READ_WRITE_CONTROL_MASK[15:8];
            end else if (cfg_addr_in == `OFS_SMM_ENABLE) begin
                sysmgmt_ram_enable_reg <= cfg_wdata_in & `MASK_SMM_ENABLE;
            end
        end
    end

    // configuration reads, unmapped offsets return zero
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_rdata_out <= 8'h00;
        end else if (cfg_rd_in) begin
            if (cfg_addr_in == `OFS_PROC_WR_CTRL) begin
                cfg_rdata_out <= processor_write_control_reg;
            end else if (cfg_addr_in == `OFS_PCI_RW_CTRL_LO) begin
                cfg_rdata_out <= pci_read_write_control_reg[7:0];
            end else if (cfg_addr_in == `OFS_PCI_RW_CTRL_HI) begin
                cfg_rdata_out <= pci_read_write_control_reg[15:8];
            end else if (cfg_addr_in == `OFS_SMM_ENABLE) begin
                cfg_rdata_out <= sysmgmt_ram_enable_reg;
            end else begin
                cfg_rdata_out <= 8'h00;
            end
        end
    end

    // posting enables
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            out_post_en_out <= 1'b0;
            in_post_en_out  <= 1'b0;
        end else begin
            out_post_en_out <= processor_write_control_reg[`BIT_OUT_POST];
            in_post_en_out  <= pci_read_write_control_reg[`BIT_IN_POST];
        end
    end

    // outbound write posting and burst assembly
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            host_wr_post_out       <= 1'b0;
            pci_burst_continue_out <= 1'b0;
            wr_chain_reg           <= 1'b0;
            wr_next_addr_reg       <= '0;
        end else begin
            host_wr_post_out <= host_wr_valid_in
                & processor_write_control_reg[`BIT_OUT_POST];
            pci_burst_continue_out <= host_wr_valid_in & wr_chain_reg
                & host_wr_combining_in & host_wr_full_line_in
                & (host_wr_addr_in == wr_next_addr_reg)
                & pci_read_write_control_reg[`BIT_BURST_ASM];
            wr_chain_reg <= host_wr_valid_in & host_wr_combining_in
                & host_wr_full_line_in;
            if (host_wr_valid_in) begin
                wr_next_addr_reg <= host_wr_addr_in + ADDR_W'(LINE_BYTES);
            end
        end
    end

    xfer_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_read_fifo (
        .clk_sys_in   (clk_sys_in),
        .rst_in       (rst_in),
        .wr_valid_in  (pci_rd_valid_in),
        .wr_ready_out (pci_rd_ready_out),
        .wr_data_in   ({pci_rd_cmd_in, pci_rd_addr_in}),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (fifo_ready),
        .rd_data_out  (fifo_data)
    );

    assign fifo_cmd   = pci_read_cmd_t'(fifo_data[FW-1:ADDR_W]);
    assign fifo_addr  = fifo_data[ADDR_W-1:0];
    assign fifo_ready = (state_reg == ST_IDLE);

    // full line and prefetch selection by read command
    always_comb begin
        plan_line = 1'b0;
        plan_pref = 1'b0;
        case (fifo_cmd)
            CMD_MEM_READ: begin
                plan_line = pci_read_write_control_reg[`BIT_MR_LINE];
                plan_pref = plan_line & pci_read_write_control_reg[`BIT_MR_PREF];
            end
            CMD_MEM_READ_MULT: begin
                plan_line = pci_read_write_control_reg[`BIT_MRM_LINE];
                plan_pref = plan_line & pci_read_write_control_reg[`BIT_MRM_PREF];
            end
            CMD_MEM_READ_LINE: begin
                plan_line = pci_read_write_control_reg[`BIT_MRL_LINE];
                plan_pref = plan_line & pci_read_write_control_reg[`BIT_MRL_PREF];
            end
            default: begin
                plan_line = 1'b0;
                plan_pref = 1'b0;
            end
        endcase
    end

    // host read issue
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_reg             <= ST_IDLE;
            host_rd_valid_out     <= 1'b0;
            host_rd_addr_out      <= '0;
            host_rd_full_line_out <= 1'b0;
            host_rd_lines_out     <= 3'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (fifo_valid) begin
                        state_reg             <= ST_HOLD;
                        host_rd_valid_out     <= 1'b1;
                        host_rd_addr_out      <= fifo_addr;
                        host_rd_full_line_out <= plan_line;
                        if (plan_pref) begin
                            host_rd_lines_out <= lines_to_page(fifo_addr);
                        end else begin
                            host_rd_lines_out <= 3'h1;
                        end
                    end
                end
                ST_HOLD: begin
                    if (host_rd_ready_in) begin
                        state_reg         <= ST_IDLE;
                        host_rd_valid_out <= 1'b0;
                    end
                end
                default: begin
                    state_reg         <= ST_IDLE;
                    host_rd_valid_out <= 1'b0;
                end
            endcase
        end
    end

    // system-management gap decode
    assign in_smm_range = (dec_addr_in >= smm_base_in)
        & (dec_addr_in <= smm_limit_in);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            dec_claim_out <= 1'b0;
        end else if (sysmgmt_ram_enable_reg[`BIT_SMM_OVERRIDE]) begin
            dec_claim_out <= dec_valid_in & normal_hit_in;
        end else if (in_smm_range) begin
            dec_claim_out <= dec_valid_in & normal_hit_in
                & sysmgmt_memory_select_n_in;
        end else begin
            dec_claim_out <= dec_valid_in & normal_hit_in;
        end
    end
endmodule

`default_nettype wire

// [bench/host_plan_sink.sv]
// host bus side taker of read plans
// assumes the bench may stall it at will
`timescale 1ns/1ps
`default_nettype none
module host_plan_sink (
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic stall_in,
    input  wire logic host_rd_valid_in,
    output logic      host_rd_ready_out
);
    logic [1:0] cnt_reg;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in)
            cnt_reg <= 2'h0;
        else if (host_rd_valid_in)
            cnt_reg <= cnt_reg + 2'h1;
    end
    // slow one cycle in four, refuses while stalled
    assign host_rd_ready_out = !stall_in && (cnt_reg != 2'h3);
endmodule
`default_nettype wire

// [bench/bridge_transfer_policy_ctrl_props.sv]
// port checker of the transfer policy block
// assumes the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module bridge_transfer_policy_ctrl_props #(
    parameter int ADDR_W     = 32,
    parameter int LINE_BYTES = 32
) (
    input wire logic              clk_sys_in,
    input wire logic              rst_in,
    input wire logic              cfg_wr_in,
    input wire logic [7:0]        cfg_addr_in,
    input wire logic [7:0]        cfg_wdata_in,
    input wire logic              out_post_en_out,
    input wire logic              in_post_en_out,
    input wire logic              host_wr_valid_in,
    input wire logic [ADDR_W-1:0] host_wr_addr_in,
    input wire logic              host_wr_combining_in,
    input wire logic              host_wr_full_line_in,
    input wire logic              pci_burst_continue_out,
    input wire logic              host_rd_valid_out,
    input wire logic [ADDR_W-1:0] host_rd_addr_out,
    input wire logic              host_rd_full_line_out,
    input wire logic [2:0]        host_rd_lines_out,
    input wire logic              dec_valid_in,
    input wire logic [ADDR_W-1:0] dec_addr_in,
    input wire logic              normal_hit_in,
    input wire logic              sysmgmt_memory_select_n_in,
    input wire logic [ADDR_W-1:0] smm_base_in,
    input wire logic [ADDR_W-1:0] smm_limit_in,
    input wire logic              dec_claim_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic ovr_reg;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in)
            ovr_reg <= 1'b0;
        else if (cfg_wr_in && cfg_addr_in == 8'h57)
            ovr_reg <= cfg_wdata_in[3];
    end
    wire in_rng = dec_addr_in >= smm_base_in && dec_addr_in <= smm_limit_in;
    wire cand = dec_valid_in && normal_hit_in;
    wire wcl = host_wr_valid_in && host_wr_combining_in && host_wr_full_line_in;
    property p_out_post;
        cfg_wr_in && cfg_addr_in == 8'h53 ##1 !(cfg_wr_in && cfg_addr_in == 8'h53)
            |=> out_post_en_out == $past(cfg_wdata_in[1], 2);
    endproperty
    a_out_post: assert property (p_out_post) else $error("outbound enable wrong");
    property p_in_post;
        cfg_wr_in && cfg_addr_in == 8'h54 ##1 !(cfg_wr_in && cfg_addr_in == 8'h54)
            |=> in_post_en_out == $past(cfg_wdata_in[0], 2);
    endproperty
    a_in_post: assert property (p_in_post) else $error("inbound enable wrong");
    property p_burst;
        pci_burst_continue_out |-> $past(wcl) && $past(wcl, 2)
            && $past(host_wr_addr_in) == $past(host_wr_addr_in, 2) + LINE_BYTES;
    endproperty
    a_burst: assert property (p_burst) else $error("burst continue unfounded");
    property p_pref;
        host_rd_valid_out && !host_rd_full_line_out |-> host_rd_lines_out == 3'h1;
    endproperty
    a_pref: assert property (p_pref) else $error("prefetch without line read");
    property p_page;
        host_rd_valid_out |-> host_rd_lines_out != 3'h0 && {1'b0, host_rd_addr_out[11:5],
            5'h00} + {5'h00, host_rd_lines_out, 5'h00} <= 13'h1000;
    endproperty
    a_page: assert property (p_page) else $error("prefetch crosses page");
    property p_ovr;
        ovr_reg && cand |=> dec_claim_out;
    endproperty
    a_ovr: assert property (p_ovr) else $error("override decode lost");
    property p_gap;
        !ovr_reg && cand && in_rng && !sysmgmt_memory_select_n_in |=> !dec_claim_out;
    endproperty
    a_gap: assert property (p_gap) else $error("gap access claimed");
    property p_outside;
        cand && !in_rng |=> dec_claim_out;
    endproperty
    a_outside: assert property (p_outside) else $error("outside access lost");
    c_burst: cover property (pci_burst_continue_out);
    c_pref: cover property (host_rd_valid_out && host_rd_lines_out == 3'h4);
    c_gap: cover property (!ovr_reg && cand && in_rng && !sysmgmt_memory_select_n_in);
endmodule
bind bridge_transfer_policy_ctrl bridge_transfer_policy_ctrl_props #(.ADDR_W(ADDR_W),
    .LINE_BYTES(LINE_BYTES)) props (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in),
    .out_post_en_out(out_post_en_out), .in_post_en_out(in_post_en_out),
    .host_wr_valid_in(host_wr_valid_in), .host_wr_addr_in(host_wr_addr_in),
    .host_wr_combining_in(host_wr_combining_in), .host_wr_full_line_in(host_wr_full_line_in),
    .pci_burst_continue_out(pci_burst_continue_out), .host_rd_valid_out(host_rd_valid_out),
    .host_rd_addr_out(host_rd_addr_out), .host_rd_full_line_out(host_rd_full_line_out),
    .host_rd_lines_out(host_rd_lines_out), .dec_valid_in(dec_valid_in),
    .dec_addr_in(dec_addr_in), .normal_hit_in(normal_hit_in),
    .sysmgmt_memory_select_n_in(sysmgmt_memory_select_n_in), .smm_base_in(smm_base_in),
    .smm_limit_in(smm_limit_in), .dec_claim_out(dec_claim_out));
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench of the transfer policy block
// assumes the plan sink on the far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bridge_transfer_policy_ctrl_pkg::*;
    localparam logic [31:0] SB = 32'h000A0000;
    localparam logic [31:0] SL = 32'h000BFFFF;
    logic        clk, rst, cw, cr, ope, ipe, hv, hc, hf, hp, hb, pv, prdy;
    logic        rv, rrdy, rfl, dv, hit, sel_n, dcl, stall, ok, rp, wp, dp;
    logic [1:0]  pc;
    logic [2:0]  rl;
    logic [7:0]  ca, cd, crd;
    logic [15:0] w;
    logic [31:0] ha, pa, da, t, ra;
    int          fail_count, n_compared, seed, cyc, n;
    logic [7:0]  q_r[$], q_p[$], q_w[$], q_d[$];
    logic [31:0] q_a[$];
    logic [7:0]  ofs[5] = '{8'h53, 8'h54, 8'h55, 8'h57, 8'h56};
    logic [7:0]  msk[5] = '{8'h02, 8'h7B, 8'h03, 8'h08, 8'h00};
    bridge_transfer_policy_ctrl dut (.clk_sys_in(clk), .rst_in(rst), .cfg_wr_in(cw),
        .cfg_rd_in(cr), .cfg_addr_in(ca), .cfg_wdata_in(cd), .cfg_rdata_out(crd),
        .out_post_en_out(ope), .in_post_en_out(ipe), .host_wr_valid_in(hv),
        .host_wr_addr_in(ha), .host_wr_combining_in(hc), .host_wr_full_line_in(hf),
        .host_wr_post_out(hp), .pci_burst_continue_out(hb), .pci_rd_valid_in(pv),
        .pci_rd_ready_out(prdy), .pci_rd_cmd_in(pc), .pci_rd_addr_in(pa),
        .host_rd_valid_out(rv), .host_rd_ready_in(rrdy), .host_rd_addr_out(ra),
        .host_rd_full_line_out(rfl), .host_rd_lines_out(rl), .dec_valid_in(dv),
        .dec_addr_in(da), .normal_hit_in(hit), .sysmgmt_memory_select_n_in(sel_n),
        .smm_base_in(SB), .smm_limit_in(SL), .dec_claim_out(dcl));
    host_plan_sink sink (.clk_sys_in(clk), .rst_in(rst), .stall_in(stall),
        .host_rd_valid_in(rv), .host_rd_ready_out(rrdy));
    task automatic finish_test();
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic idle(input int c);
        cw = 1'b0;
        cr = 1'b0;
        hv = 1'b0;
        pv = 1'b0;
        dv = 1'b0;
        repeat (c) tick();
    endtask
    task automatic cfg(input logic rd, input logic [7:0] a, input logic [7:0] d);
        cw = !rd;
        cr = rd;
        ca = a;
        cd = d;
        if (rd)
            q_r.push_back(d);
        tick();
    endtask
    task automatic hw(input logic c, input logic [31:0] a, input logic [7:0] e);
        hv = 1'b1;
        hc = c;
        ha = a;
        q_w.push_back(e);
        tick();
    endtask
    function automatic logic [7:0] plan(input logic [1:0] c, input logic [31:0] a);
        logic fl, pf;
        logic [12:0] lft;
        fl = c == CMD_MEM_READ ? w[8] : c == CMD_MEM_READ_LINE ? w[3] :
            c == CMD_MEM_READ_MULT ? w[5] : 1'b0;
        pf = c == CMD_MEM_READ ? w[9] : c == CMD_MEM_READ_LINE ? w[4] :
            c == CMD_MEM_READ_MULT ? w[6] : 1'b0;
        lft = (13'h1000 - {1'b0, a[11:0]} + 13'h001F) >> 5;
        if (fl && pf)
            return {4'h0, fl, lft > 13'h0004 ? 3'h4 : lft[2:0]};
        return {4'h0, fl, 3'h1};
    endfunction
    task automatic rdreq(input logic [1:0] c, input logic [31:0] a, input int mw);
        pv = 1'b1;
        pc = c;
        pa = a;
        ok = 1'b0;
        for (int i = 0; i < mw && !ok; i++) begin
            @(posedge clk);
            ok = prdy;
        end
        if (ok) begin
            q_p.push_back(plan(c, a));
            q_a.push_back(a);
        end
        #1;
    endtask
    task automatic drain();
        for (int i = 0; i < 400 && q_p.size() != 0; i++)
            tick();
        chk(8'(q_p.size()), 8'h00);
    endtask
    task automatic dec(input logic [31:0] a, input logic o);
        logic [2:0] r;
        r = 3'($random(seed));
        dv = r[0];
        hit = r[1];
        sel_n = r[2];
        da = a;
        if (r[0])
            q_d.push_back({7'h00, r[1] && (o || r[2] || a < SB || a > SL)});
        tick();
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    always @(posedge clk) begin
        if (rp) chk(crd, q_r.pop_front());
        if (wp) chk({6'h00, hp, hb}, q_w.pop_front());
        if (dp) chk({7'h00, dcl}, q_d.pop_front());
        if (rv && rrdy) chk({4'h0, rfl, rl}, q_p.pop_front());
        if (rv && rrdy) chk(ra, q_a.pop_front());
        rp <= cr;
        wp <= hv;
        dp <= dv;
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        seed = 32'h39;
        {rst, cw, cr, hv, hc, pv, dv, hit, stall, rp, wp, dp, sel_n, hf} = 14'h2003;
        {ca, cd, pc, ha, pa, da, w} = '0;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        idle(2);
        for (int i = 0; i < 5; i++) cfg(1'b1, ofs[i], 8'h00);
        for (int i = 0; i < 5; i++) cfg(1'b0, ofs[i], 8'hFF);
        for (int i = 0; i < 5; i++) cfg(1'b1, ofs[i], msk[i]);
        idle(2);
        chk({6'h00, ope, ipe}, 8'h03);
        for (int i = 0; i < 4; i++) hw(1'b1, 32'h1000 + 32'h20 * i, {7'h01, i != 0});
        hw(1'b0, 32'h1080, 8'h02);
        hw(1'b1, 32'h10A0, 8'h02);
        idle(1);
        hw(1'b1, 32'h10C0, 8'h02);
        hf = 1'b0;
        hw(1'b1, 32'h10E0, 8'h02);
        hf = 1'b1;
        idle(1);
        cfg(1'b0, 8'h53, 8'h00);
        cfg(1'b0, 8'h54, 8'h00);
        idle(2);
        chk({6'h00, ope, ipe}, 8'h00);
        hw(1'b1, 32'h2000, 8'h00);
        hw(1'b1, 32'h2020, 8'h00);
        idle(1);
        for (int k = 0; k < 7; k++) begin
            w = k == 0 ? 16'h037B : k == 1 ? 16'h0250 : 16'($random(seed)) & 16'h037B;
            if (k == 6)
                w = 16'h0000;
            cfg(1'b0, 8'h54, w[7:0]);
            cfg(1'b0, 8'h55, w[15:8]);
            idle(1);
            for (int j = 0; j < 8 && k < 6; j++) begin
                t = $random(seed);
                if (j < 4)
                    t[11:0] = 12'hF80 + 12'h021 * j;
                rdreq(2'(j), t, 40);
            end
            idle(1);
            drain();
        end
        stall = 1'b1;
        for (n = 0; n < 40 && (n == 0 || ok); n++)
            rdreq(CMD_MEM_READ, 32'h3000 + 32'h20 * n, 1);
        chk({7'h00, ok}, 8'h00);
        chk({7'h00, n >= 17}, 8'h01);
        stall = 1'b0;
        rdreq(CMD_MEM_READ, 32'h3000 + 32'h20 * (n - 1), 40);
        idle(1);
        drain();
        for (int o = 0; o < 2; o++) begin
            cfg(1'b0, 8'h57, o ? 8'h08 : 8'h00);
            idle(1);
            repeat (48) dec(32'h00090000 + (32'($random(seed)) & 32'h0003FFFF), o[0]);
            idle(2);
        end
        finish_test();
    end
endmodule
`default_nettype wire
